// File: inc/mgmt_regs.svh
// Timing counts and field positions of the module management logic
`ifndef MGMT_REGS_SVH
`define MGMT_REGS_SVH

`define MGMT_CLK_HZ 40000000
`define MGMT_T_INIT_MS 2000
`define MGMT_T_SERIAL_MS 2000
`define MGMT_T_DATA_MS 2000
`define MGMT_T_RESET_MS 2000
`define MGMT_T_RESET_PULSE_US 2
`define MGMT_T_LOW_POWER_REQUEST_US 100
`define MGMT_T_IRQ_ASSERT_MS 200
`define MGMT_T_IRQ_RELEASE_US 500
`define MGMT_T_LOS_MS 100
`define MGMT_T_FLAG_MS 200
`define MGMT_T_MASK_MS 100
`define MGMT_T_MODSEL_US 100
`define MGMT_T_PDOWN_ON_MS 100
`define MGMT_T_PDOWN_OFF_MS 300

// Longest times round down, least times round up
`define MGMT_INIT_CYCLES (`MGMT_T_INIT_MS * (`MGMT_CLK_HZ / 1000))
`define MGMT_PDOWN_EXIT_CYCLES (`MGMT_T_PDOWN_OFF_MS * (`MGMT_CLK_HZ / 1000))
`define MGMT_RESET_PULSE_CYCLES ((`MGMT_T_RESET_PULSE_US * (`MGMT_CLK_HZ / 1000) + 999) / 1000)

`define MGMT_NUM_LANES 4
`define MGMT_NUM_COND 3
`define MGMT_STATUS_BYTE 2
`define MGMT_STATUS_NOT_READY_BIT 0
`define MGMT_FLAG_READY_BIT 0
`define MGMT_FLAG_LOS_LSB 1

`endif

// File: inc/mgmt_pkg.sv
// Types shared by the module management logic
package mgmt_pkg;

    typedef enum logic [1:0] {
        life_init = 2'b00,
        life_ready = 2'b01,
        life_pdown = 2'b10,
        life_reset = 2'b11
    } life_state_t;

endpackage

// File: inc/wire_events_if.sv
// Two-wire bus events passed from the bus watcher to the control core
`timescale 1ns/1ps
interface wire_events_if;
    logic start;
    logic stop;
    logic commit;

    modport src
    (
        output start,
        output stop,
        output commit
    );

    modport dst
    (
        input start,
        input stop,
        input commit
    );
endinterface

// File: rtl/mgmt_timer.sv
// Down counter that reports the end of a loaded interval
`timescale 1ns/1ps
module mgmt_timer #(
    parameter int WIDTH = 27
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic busy;
        logic done;
    } timer_state_t;

    timer_state_t state;
    timer_state_t next_state;

    always_comb
    begin
        next_state = state;
        next_state.done = 1'b0;
        if (load)
        begin
            next_state.count = load_value;
            next_state.busy = 1'b1;
        end
        else if (state.busy)
        begin
            if (state.count <= WIDTH'(1))
            begin
                next_state.count = '0;
                next_state.busy = 1'b0;
                next_state.done = 1'b1;
            end
            else
            begin
                next_state.count = state.count - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign busy = state.busy;
    assign done = state.done;
endmodule

// File: rtl/mgmt_wire_watch.sv
// Watches the two-wire bus pins for start, stop and the clock fall after stop
`timescale 1ns/1ps
module mgmt_wire_watch (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    wire_events_if.src events
);
    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic scl_last;
        logic sda_last;
        logic armed;
        logic start;
        logic stop;
        logic commit;
    } watch_state_t;

    watch_state_t state;
    watch_state_t next_state;

    always_comb
    begin
        logic scl;
        logic sda;
        scl = 1'b1;
        sda = 1'b1;
        next_state = state;
        scl = state.scl_sync[1];
        sda = state.sda_sync[1];
        next_state.scl_sync = {state.scl_sync[0], scl_in};
        next_state.sda_sync = {state.sda_sync[0], sda_in};
        next_state.scl_last = scl;
        next_state.sda_last = sda;
        next_state.start = scl & state.scl_last & state.sda_last & ~sda;
        next_state.stop = scl & state.scl_last & ~state.sda_last & sda;
        next_state.commit = 1'b0;
        if (next_state.stop)
        begin
            next_state.armed = 1'b1;
        end
        else if (state.armed && state.scl_last && !scl)
        begin
            // Falling clock edge after the stop closes the transaction
            next_state.armed = 1'b0;
            next_state.commit = 1'b1; // [R18] [R19]
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_last: 1'b1, sda_last: 1'b1, default: '0};
        end
        else
        begin
            state <= next_state;
        end
    end

    assign events.start = state.start;
    assign events.stop = state.stop;
    assign events.commit = state.commit;
endmodule

// File: rtl/mgmt_control.sv
// Low-speed control, flag, mask and power management core of the module
//
// Contract
// [R1] Fully functional within 2000 ms of power-on, insertion or reset release.
// [R2] Reset recognised only after reset input held low at least 2 us.
// [R3] Two-wire bus answers within 2000 ms of power-on.
// [R4] Within 2000 ms clear data-not-ready bit and assert interrupt.
// [R5] Fully functional within 2000 ms after reset pulse ends.
// [R6] Low-power request high: lower power within 100 us.
// [R7] Interrupt condition drives interrupt output low within 200 ms.
// [R8] Flags clear on read; interrupt releases within 500 us after that.
// [R9] Loss of signal sets its flag and interrupt within 100 ms.
// [R10] Any flag condition sets its flag and interrupt within 200 ms.
// [R11] Setting a mask stops its flag interrupting within 100 ms.
// [R12] Clearing a mask resumes its flag interrupting within 100 ms.
// [R13] Module select asserted: answer the bus within 100 us.
// [R14] Module select released: stop answering the bus within 100 us.
// [R15] Power-down bit set: lower power within 100 ms.
// [R16] Power-down bit cleared: fully functional within 300 ms.
// [R17] Fully functional shown by interrupt from data-not-ready deasserting.
// [R18] Clear-on-read timing counts from clock fall after read stop.
// [R19] Mask or power-down write timing counts from clock fall after stop.
// [R20] Host reads the flag field after interrupt to find the cause.
// [R21] Interrupt stays asserted while any unmasked flag is set.
// [R22] Every time limit is kept by counters on the management clock; here only init, power-down exit and reset pulse are counted.
`timescale 1ns/1ps
`include "mgmt_regs.svh"
module mgmt_control #(
    parameter int LANES = `MGMT_NUM_LANES,
    parameter int CONDS = `MGMT_NUM_COND,
    parameter int unsigned INIT_CYCLES = `MGMT_INIT_CYCLES,
    parameter int unsigned PDOWN_EXIT_CYCLES = `MGMT_PDOWN_EXIT_CYCLES,
    parameter int unsigned RESET_PULSE_CYCLES = `MGMT_RESET_PULSE_CYCLES,
    localparam int FLAGS = 1 + LANES + CONDS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_request,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [LANES-1:0] los_in,
    input wire logic [CONDS-1:0] cond_in,
    input wire logic flag_read,
    input wire logic [FLAGS-1:0] flag_read_sel,
    input wire logic mask_write,
    input wire logic [FLAGS-1:0] mask_wdata,
    input wire logic pdown_write,
    input wire logic pdown_wdata,
    output logic interrupt_out_n,
    output logic module_present_n,
    output logic bus_respond,
    output logic low_power_active,
    output logic data_not_ready,
    output logic [FLAGS-1:0] flag_status,
    output logic [FLAGS-1:0] mask_status,
    output logic pdown_status
);
    localparam int TW = $clog2(INIT_CYCLES + 1);
    localparam int RW = $clog2(RESET_PULSE_CYCLES + 1);
    localparam int NA = 3 + LANES + CONDS;

    typedef struct packed {
        logic [NA-1:0] sync1;
        logic [NA-1:0] sync2;
        logic [NA-1:0] last;
        logic [RW-1:0] reset_low_count;
        logic reset_seen;
        mgmt_pkg::life_state_t life;
        logic kick;
        logic kick_long;
        logic [FLAGS-1:0] flags;
        logic [FLAGS-1:0] mask;
        logic [FLAGS-1:0] pend_clear;
        logic [FLAGS-1:0] pend_mask;
        logic pend_mask_valid;
        logic pdown;
        logic pend_pdown;
        logic pend_pdown_valid;
        logic not_ready;
        logic irq_n;
        logic respond;
        logic low_power;
    } ctrl_state_t;

    ctrl_state_t state;
    ctrl_state_t next_state;

    wire_events_if bus_events ();

    logic timer_busy;
    logic timer_done;
    logic [TW-1:0] timer_value;

    mgmt_wire_watch u_watch (
        .clk(clk),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .events(bus_events.src)
    );

    // Init and power-down exit intervals share one counter
    assign timer_value = state.kick_long ? TW'(INIT_CYCLES) : TW'(PDOWN_EXIT_CYCLES); // [R22]

    mgmt_timer #(
        .WIDTH(TW)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .load(state.kick),
        .load_value(timer_value),
        .busy(timer_busy),
        .done(timer_done)
    );

    always_comb
    begin
        logic sel_n;
        logic reset_n;
        logic lp_req;
        logic [LANES-1:0] los;
        logic [CONDS-1:0] cond;
        logic [FLAGS-1:0] set_events;
        logic [FLAGS-1:0] clear_now;
        logic reset_rise;
        sel_n = 1'b1;
        reset_n = 1'b1;
        lp_req = 1'b0;
        los = '0;
        cond = '0;
        set_events = '0;
        clear_now = '0;
        reset_rise = 1'b0;
        next_state = state;

        // Two flip-flops on every pin before use
        next_state.sync1 = {low_power_request, module_reset_n, module_select_n, los_in, cond_in};
        next_state.sync2 = state.sync1;
        next_state.last = state.sync2;
        {lp_req, reset_n, sel_n, los, cond} = state.sync2;

        next_state.kick = 1'b0;

        // Reset pulse qualification
        if (!reset_n)
        begin
            if (state.reset_low_count >= RW'(RESET_PULSE_CYCLES))
            begin
                next_state.reset_seen = 1'b1; // [R2]
            end
            else
            begin
                next_state.reset_low_count = state.reset_low_count + RW'(1);
            end
        end
        else
        begin
            next_state.reset_low_count = '0;
            next_state.reset_seen = 1'b0;
            reset_rise = state.reset_seen;
        end

        // Latched flags set on the rising edge of their condition
        set_events[`MGMT_FLAG_LOS_LSB +: LANES] = los & ~state.last[CONDS +: LANES]; // [R9]
        set_events[FLAGS-1 -: CONDS] = cond & ~state.last[CONDS-1:0]; // [R10]

        // Read and write effects wait for the clock fall after the stop
        next_state.pend_clear = state.pend_clear | (flag_read ? flag_read_sel : '0);
        if (mask_write)
        begin
            next_state.pend_mask = mask_wdata;
            next_state.pend_mask_valid = 1'b1;
        end
        if (pdown_write)
        begin
            next_state.pend_pdown = pdown_wdata;
            next_state.pend_pdown_valid = 1'b1;
        end

        if (bus_events.commit)
        begin
            clear_now = next_state.pend_clear; // [R8] [R18]
            next_state.pend_clear = '0;
            if (next_state.pend_mask_valid)
            begin
                next_state.mask = next_state.pend_mask; // [R11] [R12] [R19]
                next_state.pend_mask_valid = 1'b0;
            end
            if (next_state.pend_pdown_valid)
            begin
                next_state.pdown = next_state.pend_pdown; // [R19]
                next_state.pend_pdown_valid = 1'b0;
            end
        end

        case (state.life)
            mgmt_pkg::life_init:
            begin
                if (timer_done)
                begin
                    // Data ready: status bit drops and a ready flag interrupts
                    next_state.life = mgmt_pkg::life_ready;
                    next_state.not_ready = 1'b0; // [R4] [R17]
                    set_events[`MGMT_FLAG_READY_BIT] = 1'b1; // [R1] [R5] [R16] [R17]
                end
                else if (!timer_busy && !state.kick)
                begin
                    next_state.kick = 1'b1;
                end
            end
            mgmt_pkg::life_ready:
            begin
                if (next_state.pdown)
                begin
                    next_state.life = mgmt_pkg::life_pdown; // [R15]
                end
            end
            mgmt_pkg::life_pdown:
            begin
                if (!next_state.pdown)
                begin
                    next_state.life = mgmt_pkg::life_init; // [R16]
                    next_state.not_ready = 1'b1;
                    next_state.kick = 1'b1;
                    next_state.kick_long = 1'b0;
                end
            end
            mgmt_pkg::life_reset:
            begin
                if (reset_rise)
                begin
                    next_state.life = mgmt_pkg::life_init; // [R5]
                    next_state.kick = 1'b1;
                    next_state.kick_long = 1'b1;
                end
            end
            default:
            begin
                next_state.life = mgmt_pkg::life_reset;
            end
        endcase

        // A qualified reset holds the module until the pin rises
        if (next_state.reset_seen && !reset_rise)
        begin
            next_state.life = mgmt_pkg::life_reset;
            next_state.not_ready = 1'b1;
            next_state.flags = '0;
            next_state.mask = '0;
            next_state.pdown = 1'b0;
            next_state.pend_clear = '0;
            next_state.pend_mask_valid = 1'b0;
            next_state.pend_pdown_valid = 1'b0;
            next_state.kick = 1'b0;
        end
        else
        begin
            // A set in the same cycle as its clear wins
            next_state.flags = (state.flags & ~clear_now) | set_events; // [R8] [R10]
        end

        // Interrupt low while any unmasked flag stands
        next_state.irq_n = ~|(next_state.flags & ~next_state.mask); // [R7] [R11] [R12] [R21]

        next_state.respond = (next_state.life != mgmt_pkg::life_reset)
            && (next_state.life != mgmt_pkg::life_init || !state.kick_long || state.life == mgmt_pkg::life_pdown)
            && !sel_n; // [R3] [R13] [R14]
        if (state.life == mgmt_pkg::life_init && state.kick_long)
        begin
            next_state.respond = 1'b0; // [R3]
        end

        next_state.low_power = lp_req || next_state.pdown
            || (next_state.life == mgmt_pkg::life_pdown); // [R6] [R15]
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= '{
                sync1: {1'b0, 1'b1, 1'b1, {(LANES + CONDS){1'b0}}},
                sync2: {1'b0, 1'b1, 1'b1, {(LANES + CONDS){1'b0}}},
                last: {1'b0, 1'b1, 1'b1, {(LANES + CONDS){1'b0}}},
                life: mgmt_pkg::life_init,
                kick: 1'b1,
                kick_long: 1'b1,
                not_ready: 1'b1,
                irq_n: 1'b1,
                default: '0
            };
        end
        else
        begin
            state <= next_state;
        end
    end

    assign interrupt_out_n = state.irq_n;
    assign module_present_n = 1'b0;
    assign bus_respond = state.respond;
    assign low_power_active = state.low_power;
    assign data_not_ready = state.not_ready;
    assign flag_status = state.flags;
    assign mask_status = state.mask;
    assign pdown_status = state.pdown;
endmodule

// File: tb/mgmt_control_properties.sv
// Timing checks on the module management control core
`timescale 1ns/1ps
module mgmt_control_checker #(
    parameter int LANES = 4,
    parameter int CONDS = 3,
    parameter int unsigned INIT_CYCLES = 200
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_request,
    input wire logic [LANES-1:0] los_in,
    input wire logic [CONDS-1:0] cond_in,
    input wire logic interrupt_out_n,
    input wire logic bus_respond,
    input wire logic low_power_active,
    input wire logic data_not_ready,
    input wire logic [LANES+CONDS:0] flag_status,
    input wire logic [LANES+CONDS:0] mask_status,
    input wire logic pdown_status
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [31:0] wait_cnt;
    // Cycles spent not ready outside reset and power-down
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            wait_cnt <= '0;
        else if (!module_reset_n || !data_not_ready || pdown_status)
            wait_cnt <= '0;
        else
            wait_cnt <= wait_cnt + 32'h1;
    end
    sequence lane_lost;
        $rose(los_in[0]);
    endsequence
    sequence lane_flagged;
        ##[1:5] flag_status[1];
    endsequence
    los_flag_set_a: assert property (lane_lost |-> lane_flagged)
        else $error("lane loss flag late");
    cond_flag_set_a: assert property ($rose(cond_in[0]) |-> ##[1:5] flag_status[LANES+1])
        else $error("condition flag late");
    irq_assert_a: assert property ((flag_status & ~mask_status) != '0 |-> !interrupt_out_n)
        else $error("interrupt not asserted");
    irq_release_a: assert property (((flag_status & ~mask_status) == '0) [*2] |-> interrupt_out_n)
        else $error("interrupt not released");
    ready_in_time_a: assert property (wait_cnt <= INIT_CYCLES + 10)
        else $error("not ready in time");
    ready_irq_a: assert property ($fell(data_not_ready) && !mask_status[0] |-> flag_status[0] ##[1:2] !interrupt_out_n)
        else $error("ready without interrupt");
    select_off_a: assert property ($rose(module_select_n) |-> ##[1:5] !bus_respond)
        else $error("bus still answers");
    select_on_a: assert property ($fell(module_select_n) && !data_not_ready && module_reset_n && !pdown_status
        |-> ##[1:5] bus_respond)
        else $error("bus not answering");
    low_power_a: assert property (low_power_request [*4] |-> low_power_active)
        else $error("low power late");
    pdown_power_a: assert property ($rose(pdown_status) |-> low_power_active)
        else $error("power-down without low power");
    pdown_exit_a: assert property ($fell(pdown_status) && module_reset_n |-> ##[1:110] !data_not_ready)
        else $error("power-down exit late");
endmodule

bind mgmt_control mgmt_control_checker #(.LANES(LANES), .CONDS(CONDS), .INIT_CYCLES(INIT_CYCLES))
    i_mgmt_control_checker (.clk, .rst, .module_select_n, .module_reset_n, .low_power_request, .los_in,
    .cond_in, .interrupt_out_n, .bus_respond, .low_power_active, .data_not_ready, .flag_status,
    .mask_status, .pdown_status);

// File: tb/mgmt_host_model.sv
// Host controller model driving two-wire bus frames
`timescale 1ns/1ps
module mgmt_host_model (
    input wire logic go,
    input wire logic slow,
    output logic scl,
    output logic sda,
    output logic busy
);
    realtime half;
    // Bus idles high and the clock stands still between frames
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
        busy = 1'b0;
        forever
        begin
            @(posedge go);
            busy = 1'b1;
            half = slow ? 200.0 : 100.0;
            sda = 1'b0;
            #half scl = 1'b0;
            repeat (3)
            begin
                #half sda = ~sda;
                #half scl = 1'b1;
                #half scl = 1'b0;
            end
            #half sda = 1'b0;
            #half scl = 1'b1;
            #half sda = 1'b1;
            #half scl = 1'b0;
            #half scl = 1'b1;
            busy = 1'b0;
        end
    end
endmodule

// File: tb/mgmt_control_bench.sv
// Self-checking bench for the module management control core
`timescale 1ns/1ps
module mgmt_control_bench;
    localparam int unsigned INIT = 200;
    localparam int unsigned EXIT = 100;
    logic clk, rst, module_select_n, module_reset_n, low_power_request, scl_in, sda_in, go, slow, busy;
    logic flag_read, mask_write, pdown_write, pdown_wdata, interrupt_out_n, module_present_n;
    logic bus_respond, low_power_active, data_not_ready, pdown_status;
    logic [3:0] los_in;
    logic [2:0] cond_in;
    logic [7:0] flag_read_sel, mask_wdata, flag_status, mask_status;
    int err_total = 0;
    int tests_run = 0;

    mgmt_control #(.INIT_CYCLES(INIT), .PDOWN_EXIT_CYCLES(EXIT), .RESET_PULSE_CYCLES(8)) i_mgmt_control (
        .clk, .rst, .module_select_n, .module_reset_n, .low_power_request, .scl_in, .sda_in, .los_in,
        .cond_in, .flag_read, .flag_read_sel, .mask_write, .mask_wdata, .pdown_write, .pdown_wdata,
        .interrupt_out_n, .module_present_n, .bus_respond, .low_power_active, .data_not_ready,
        .flag_status, .mask_status, .pdown_status);
    mgmt_host_model i_mgmt_host_model (.go, .slow, .scl(scl_in), .sda(sda_in), .busy);

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_vec(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic strobe(input logic [1:0] kind, input logic [7:0] v);
        flag_read = kind == 2'h0;
        flag_read_sel = v;
        mask_write = kind == 2'h1;
        mask_wdata = v;
        pdown_write = kind == 2'h2;
        pdown_wdata = v[0];
        tick(1);
        flag_read = 1'b0;
        mask_write = 1'b0;
        pdown_write = 1'b0;
    endtask

    // One bus frame; its stop and following clock fall commit the strobes
    task automatic commit;
        go = 1'b1;
        tick(1);
        go = 1'b0;
        repeat (400)
            if (busy)
                tick(1);
        tick(4);
    endtask

    task automatic access(input logic [1:0] kind, input logic [7:0] v);
        strobe(kind, v);
        commit;
    endtask

    task automatic test_init;
        check_bit(data_not_ready, 1'b1);
        check_bit(bus_respond, 1'b0);
        check_bit(module_present_n, 1'b0);
        tick(INIT + 6);
        check_bit(data_not_ready, 1'b0);
        check_vec(flag_status, 8'h01);
        check_bit(interrupt_out_n, 1'b0);
        check_bit(bus_respond, 1'b1);
        access(2'h0, 8'h01);
        check_vec(flag_status, 8'h00);
        check_bit(interrupt_out_n, 1'b1);
    endtask

    task automatic test_los;
        los_in = 4'h5;
        tick(6);
        check_vec(flag_status, 8'h0a);
        check_bit(interrupt_out_n, 1'b0);
        access(2'h0, 8'h02);
        check_vec(flag_status, 8'h08);
        check_bit(interrupt_out_n, 1'b0);
        slow = 1'b1;
        access(2'h0, 8'h08);
        slow = 1'b0;
        check_bit(interrupt_out_n, 1'b1);
        los_in = 4'h0;
    endtask

    task automatic test_mask;
        strobe(2'h1, 8'h20);
        check_vec(mask_status, 8'h00);
        commit;
        check_vec(mask_status, 8'h20);
        cond_in = 3'h1;
        tick(6);
        check_vec(flag_status, 8'h20);
        check_bit(interrupt_out_n, 1'b1);
        access(2'h1, 8'h00);
        check_bit(interrupt_out_n, 1'b0);
        access(2'h0, 8'h20);
        check_bit(interrupt_out_n, 1'b1);
        cond_in = 3'h0;
    endtask

    task automatic test_select;
        module_select_n = 1'b1;
        tick(6);
        check_bit(bus_respond, 1'b0);
        module_select_n = 1'b0;
        tick(6);
        check_bit(bus_respond, 1'b1);
    endtask

    task automatic test_power;
        low_power_request = 1'b1;
        tick(5);
        check_bit(low_power_active, 1'b1);
        low_power_request = 1'b0;
        access(2'h2, 8'h01);
        check_bit(pdown_status, 1'b1);
        check_bit(low_power_active, 1'b1);
        access(2'h2, 8'h00);
        check_bit(low_power_active, 1'b0);
        tick(EXIT + 6);
        check_bit(data_not_ready, 1'b0);
        check_vec(flag_status, 8'h01);
        check_bit(interrupt_out_n, 1'b0);
    endtask

    task automatic test_reset;
        module_reset_n = 1'b0;
        tick(4);
        module_reset_n = 1'b1;
        tick(6);
        check_vec(flag_status, 8'h01);
        module_reset_n = 1'b0;
        tick(20);
        check_bit(data_not_ready, 1'b1);
        check_vec(flag_status, 8'h00);
        check_bit(interrupt_out_n, 1'b1);
        module_reset_n = 1'b1;
        tick(INIT + 10);
        check_bit(data_not_ready, 1'b0);
        check_bit(interrupt_out_n, 1'b0);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        #200us;
        err_total++;
        complete_run;
    end

    initial
    begin
        rst = 1'b1;
        module_select_n = 1'b0;
        module_reset_n = 1'b1;
        low_power_request = 1'b0;
        go = 1'b0;
        slow = 1'b0;
        los_in = 4'h0;
        cond_in = 3'h0;
        flag_read = 1'b0;
        flag_read_sel = 8'h00;
        mask_write = 1'b0;
        mask_wdata = 8'h00;
        pdown_write = 1'b0;
        pdown_wdata = 1'b0;
        tick(12);
        rst = 1'b0;
        test_init;
        test_los;
        test_mask;
        test_select;
        test_power;
        test_reset;
        complete_run;
    end
endmodule
